// >>> dsg_guard.v
// Purpose: soft gain ramp and long average power guard, banked per main converter
// Assumes: all inputs synchronous to clk_sys; gain_q: 0 = zero, 32 = unity
// Notes: register reads return data one cycle after the read strobe
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "dsg_consts.vh"

module dsg_guard
(
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// register port
	input  wire [11:0] reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	// fault and event sources, one bit per bank; rotation_arm and link_irq_trigger are single bits
	input  wire [1:0]  short_power_fault,
	input  wire [1:0]  link_fault,
	input  wire [1:0]  sync_rotation,
	input  wire        rotation_arm,
	input  wire [1:0]  transmit_gate_input,
	input  wire        link_irq_trigger,
	// interpolation setup, shared by both banks
	input  wire [3:0]  main_interp,
	input  wire [3:0]  chan_interp,
	// sample streams, 16-bit signed per bank
	input  wire [31:0] sample_i,
	input  wire [31:0] sample_q,
	// outputs
	output reg         interrupt_pin_a,
	output reg         interrupt_pin_b,
	output wire [11:0] gain_level,
	output wire [1:0]  ramping
);

	////////////////////////////////////////////////////////////////////////
	// shared registers
	reg  [0:0] converter_bank_select_q;
	reg        link_irq_pin_select_q;

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			converter_bank_select_q <= 1'b0;
			link_irq_pin_select_q   <= 1'b0;
			interrupt_pin_a         <= 1'b0;
			interrupt_pin_b         <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == `DSG_A_BANK_SEL)
				converter_bank_select_q <= reg_wdata[0];
			if (reg_wr && reg_addr == `DSG_A_IRQ_ROUTE)
				link_irq_pin_select_q <= reg_wdata[0];
			interrupt_pin_a <= link_irq_trigger & ~link_irq_pin_select_q;
			interrupt_pin_b <= link_irq_trigger & link_irq_pin_select_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// averaging clock period in system clocks, common to both banks
	reg  [31:0] pa_full;
	wire [7:0]  pa_period = pa_full[7:0];

	always @*
	begin
		if (main_interp > 4'd1)
			pa_full = `DSG_PA_MAIN_MUL * {28'h0000000, main_interp};
		else if (chan_interp > 4'd1)
			pa_full = `DSG_PA_CHAN_MUL * {28'h0000000, main_interp};
		else
			pa_full = `DSG_PA_PLAIN;
	end

	////////////////////////////////////////////////////////////////////////
	// per-bank state
	localparam ST_ZERO  = 4'b0001;
	localparam ST_UP    = 4'b0010;
	localparam ST_UNITY = 4'b0100;
	localparam ST_DOWN  = 4'b1000;

	reg [7:0]  gain_ctrl_q  [0:1];
	reg [7:0]  fade_out_q   [0:1];
	reg [7:0]  fade_in_q    [0:1];
	reg [7:0]  limit_lo_q   [0:1];
	reg [4:0]  limit_hi_q   [0:1];
	reg [7:0]  long_ctrl_q  [0:1];
	reg [12:0] reading_q    [0:1];
	reg [3:0]  state_q      [0:1];
	reg [5:0]  gain_q       [0:1];
	reg [14:0] step_cnt_q   [0:1];
	reg        txg_prev_q   [0:1];
	reg [7:0]  pa_cnt_q     [0:1];
	reg [36:0] acc_q        [0:1];
	reg [24:0] win_cnt_q    [0:1];
	reg        long_fault_q [0:1];
	reg        sw_off_q     [0:1];
	reg        sw_on_q      [0:1];

	genvar b;
	generate
		for (b = 0; b < `DSG_BANKS; b = b + 1)
		begin : g_bank
			wire        sel = (converter_bank_select_q == b);
			wire        wr  = reg_wr & sel;
			wire [12:0] limit = {limit_hi_q[b], limit_lo_q[b]};
			wire [5:0]  i6 = sample_i[16*b+15 -: `DSG_MSB_BITS];
			wire [5:0]  q6 = sample_q[16*b+15 -: `DSG_MSB_BITS];
			wire [5:0]  ia = i6[5] ? (~i6 + 6'h01) : i6;
			wire [5:0]  qa = q6[5] ? (~q6 + 6'h01) : q6;
			wire [11:0] isq = ia * ia;
			wire [11:0] qsq = qa * qa;
			wire [12:0] pwr = {1'b0, isq} + {1'b0, qsq};
			wire [3:0]  texp = long_ctrl_q[b][3:0];
			// longest window is 2^24 periods, so counter and sum are sized for it
			wire [24:0] win_len = 25'h0000001 << (`DSG_WIN_BASE_EXP + texp);
			wire [36:0] acc_sum = acc_q[b] + {24'h000000, pwr};
			wire [36:0] avg = acc_sum >> (`DSG_WIN_BASE_EXP + texp);
			wire [2:0]  rate = gain_ctrl_q[b][2:0];
			// 2^(rate+8) clocks over 32 steps: 2^(rate+3) clocks a step
			wire [14:0] step_len = 15'h0008 << rate;
			wire        gate = gain_ctrl_q[b][`DSG_B_RAMP_GATE];
			wire        txg_fall = txg_prev_q[b] & ~transmit_gate_input[b];
			wire        off_req =
				(short_power_fault[b] & fade_out_q[b][`DSG_B_SHORT_FADE]) |
				(long_fault_q[b] & fade_out_q[b][`DSG_B_LONG_FADE]) |
				(link_fault[b] & fade_out_q[b][`DSG_B_LINK_FADE]) |
				(sync_rotation[b] & rotation_arm &
				 fade_out_q[b][`DSG_B_ROT_FADE]) |
				(txg_fall & fade_out_q[b][`DSG_B_TXG_FADE]) |
				sw_off_q[b];
			// level condition: long power back under the limit after a window
			wire        level_ok = long_ctrl_q[b][`DSG_B_LONG_EN] &
			                       reading_q[b] <= limit;
			wire        on_req = (level_ok & fade_in_q[b][`DSG_B_LEVEL_ON]) |
			                     sw_on_q[b];
			wire        win_end = long_ctrl_q[b][`DSG_B_LONG_EN] &
			                      pa_cnt_q[b] == 8'h00 &&
			                      win_cnt_q[b] == win_len - 25'h0000001;

			assign gain_level[6*b+5 -: 6] = gain_q[b];
			assign ramping[b] = (state_q[b] == ST_UP) | (state_q[b] == ST_DOWN);

			always @(posedge clk_sys)
			begin
				if (!rst_n)
				begin
					gain_ctrl_q[b]  <= `DSG_RST_GAIN_CTRL;
					fade_out_q[b]   <= `DSG_RST_FADE_OUT;
					fade_in_q[b]    <= `DSG_RST_FADE_IN;
					limit_lo_q[b]   <= `DSG_RST_ZERO;
					limit_hi_q[b]   <= 5'h00;
					long_ctrl_q[b]  <= `DSG_RST_ZERO;
					reading_q[b]    <= 13'h0000;
					state_q[b]      <= ST_UNITY;
					gain_q[b]       <= `DSG_GAIN_STEPS;
					step_cnt_q[b]   <= 15'h0000;
					txg_prev_q[b]   <= 1'b0;
					pa_cnt_q[b]     <= 8'h00;
					acc_q[b]        <= 37'h0000000000;
					win_cnt_q[b]    <= 25'h0000000;
					long_fault_q[b] <= 1'b0;
					sw_off_q[b]     <= 1'b0;
					sw_on_q[b]      <= 1'b0;
				end
				else
				begin
					txg_prev_q[b] <= transmit_gate_input[b];
					sw_off_q[b] <= 1'b0;
					sw_on_q[b]  <= 1'b0;
					// register writes, banked
					if (wr)
					begin
						case (reg_addr)
						`DSG_A_GAIN_CTRL:
							gain_ctrl_q[b] <= {reg_wdata[7], 4'h0, reg_wdata[2:0]};
						`DSG_A_FADE_OUT_EN:
						begin
							fade_out_q[b] <= {reg_wdata[7:6], 2'b00, reg_wdata[3:0]};
							sw_off_q[b] <= reg_wdata[`DSG_B_SW_OFF];
						end
						`DSG_A_FADE_IN_EN:
						begin
							fade_in_q[b] <= reg_wdata;
							sw_on_q[b] <= reg_wdata[`DSG_B_SW_ON];
						end
						`DSG_A_LIMIT_LO:
							limit_lo_q[b] <= reg_wdata;
						`DSG_A_LIMIT_HI:
							limit_hi_q[b] <= reg_wdata[4:0];
						`DSG_A_LONG_CTRL:
							long_ctrl_q[b] <= {reg_wdata[7], 3'h0, reg_wdata[3:0]};
						default:
							;
						endcase
					end

					// long power averaging
					if (!long_ctrl_q[b][`DSG_B_LONG_EN])
					begin
						// held idle and cleared while disabled
						pa_cnt_q[b]     <= 8'h00;
						win_cnt_q[b]    <= 25'h0000000;
						acc_q[b]        <= 37'h0000000000;
						long_fault_q[b] <= 1'b0;
					end
					else if (pa_cnt_q[b] == 8'h00)
					begin
						// one sample per averaging clock period
						pa_cnt_q[b] <= pa_period - 8'h01;
						if (win_end)
						begin
							// the last sample of the window is part of its sum
							reading_q[b] <= avg[12:0] | {13{|avg[36:13]}};
							long_fault_q[b] <= (avg[12:0] > limit) | (|avg[36:13]);
							acc_q[b] <= 37'h0000000000;
							win_cnt_q[b] <= 25'h0000000;
						end
						else
						begin
							acc_q[b] <= acc_sum;
							win_cnt_q[b] <= win_cnt_q[b] + 25'h0000001;
						end
					end
					else
						pa_cnt_q[b] <= pa_cnt_q[b] - 8'h01;

					// gain ramp
					case (state_q[b])
					ST_UNITY:
						if (gate && off_req)
						begin
							state_q[b] <= ST_DOWN;
							step_cnt_q[b] <= 15'h0000;
						end
					ST_ZERO:
						if (gate && on_req)
						begin
							state_q[b] <= ST_UP;
							step_cnt_q[b] <= 15'h0000;
						end
					ST_DOWN, ST_UP:
						if (step_cnt_q[b] == step_len - 15'h0001)
						begin
							step_cnt_q[b] <= 15'h0000;
							if (state_q[b] == ST_DOWN)
							begin
								gain_q[b] <= gain_q[b] - 6'h01;
								if (gain_q[b] == 6'h01)
									state_q[b] <= ST_ZERO;
							end
							else
							begin
								gain_q[b] <= gain_q[b] + 6'h01;
								if (gain_q[b] == `DSG_GAIN_STEPS - 6'h01)
									state_q[b] <= ST_UNITY;
							end
						end
						else
							step_cnt_q[b] <= step_cnt_q[b] + 15'h0001;
					default:
						state_q[b] <= ST_UNITY;
					endcase
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// read port, banked registers follow the bank select
	wire bs = converter_bank_select_q[0];

	always @(posedge clk_sys)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			case (reg_addr)
			`DSG_A_BANK_SEL:    reg_rdata <= {7'h00, converter_bank_select_q};
			`DSG_A_IRQ_ROUTE:   reg_rdata <= {7'h00, link_irq_pin_select_q};
			`DSG_A_GAIN_CTRL:   reg_rdata <= gain_ctrl_q[bs];
			`DSG_A_FADE_OUT_EN: reg_rdata <= fade_out_q[bs];
			`DSG_A_FADE_IN_EN:  reg_rdata <= fade_in_q[bs];
			`DSG_A_LIMIT_LO:    reg_rdata <= limit_lo_q[bs];
			`DSG_A_LIMIT_HI:    reg_rdata <= {3'h0, limit_hi_q[bs]};
			`DSG_A_LONG_CTRL:   reg_rdata <= long_ctrl_q[bs];
			`DSG_A_READ_LO:     reg_rdata <= reading_q[bs][7:0];
			`DSG_A_READ_HI:     reg_rdata <= {3'h0, reading_q[bs][12:8]};
			default:            reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

endmodule

// >>> dsg_consts.vh
// Purpose: constants for the soft gain ramp and long power guard
// Assumes: 8-bit register port, 12-bit register addresses
// Notes: all offsets, banked single-bit field positions and 8-bit register reset values live here
`ifndef DSG_CONSTS_VH
`define DSG_CONSTS_VH

`define DSG_ADDR_W          12
`define DSG_BANKS           2
`define DSG_A_BANK_SEL      12'h008
`define DSG_A_IRQ_ROUTE     12'h4bc
`define DSG_A_GAIN_CTRL     12'h580
`define DSG_A_FADE_OUT_EN   12'h581
`define DSG_A_FADE_IN_EN    12'h582
`define DSG_A_LIMIT_LO      12'h583
`define DSG_A_LIMIT_HI      12'h584
`define DSG_A_LONG_CTRL     12'h585
`define DSG_A_READ_LO       12'h586
`define DSG_A_READ_HI       12'h587

`define DSG_RST_GAIN_CTRL   8'h00
`define DSG_RST_FADE_OUT    8'hc6
`define DSG_RST_FADE_IN     8'h40
`define DSG_RST_ZERO        8'h00

`define DSG_B_RAMP_GATE     7
`define DSG_B_SHORT_FADE    7
`define DSG_B_LONG_FADE     6
`define DSG_B_LINK_FADE     3
`define DSG_B_ROT_FADE      2
`define DSG_B_TXG_FADE      1
`define DSG_B_SW_OFF        0
`define DSG_B_SW_ON         7
`define DSG_B_LEVEL_ON      6
`define DSG_B_LONG_EN       7

`define DSG_GAIN_STEPS      6'd32
`define DSG_RAMP_BASE_EXP   8
`define DSG_WIN_BASE_EXP    9
`define DSG_PA_MAIN_MUL     4
`define DSG_PA_CHAN_MUL     8
`define DSG_PA_PLAIN        32
`define DSG_MSB_BITS        6

`endif

// >>> dsg_guard_properties.sv
// Purpose: port-level checks for dsg_guard
// Assumes: bank 0 gain at gain_level[5:0], 32 = unity
// Notes: step spacing holds for the fastest rate, 8 clocks a step
`timescale 1ns/1ns
module dsg_guard_props
(
	// clock and reset
	input wire        clk_sys,
	input wire        rst_n,
	// register port
	input wire [11:0] reg_addr,
	input wire        reg_rd,
	input wire [7:0]  reg_rdata,
	// link interrupt
	input wire        link_irq_trigger,
	input wire        interrupt_pin_a,
	input wire        interrupt_pin_b,
	// gain
	input wire [11:0] gain_level,
	input wire [1:0]  ramping
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	wire [5:0] g0 = gain_level[5:0];
	sequence s_step;
		ramping[0] && $changed(g0);
	endsequence
	////////////////////////////////////////////////////////////////
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its slot");
	a_read_unmapped: assert property (reg_rd && reg_addr == 12'h7ff |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_irq_one_pin: assert property (!(interrupt_pin_a && interrupt_pin_b))
		else $error("both interrupt pins high");
	a_irq_has_source: assert property (interrupt_pin_a || interrupt_pin_b |-> $past(link_irq_trigger))
		else $error("interrupt pin without trigger");
	a_gain_in_range: assert property (g0 <= 6'd32 && gain_level[11:6] <= 6'd32)
		else $error("gain above unity");
	a_gain_hold: assert property (!ramping[0] && !$past(ramping[0]) |-> $stable(g0))
		else $error("gain moved while idle");
	a_step_size: assert property (s_step |-> g0 == $past(g0) + 6'd1 || g0 + 6'd1 == $past(g0))
		else $error("gain step not one");
	a_step_space: assert property (s_step |=> $stable(g0)[*7])
		else $error("gain steps too close");
	a_ramp_end_value: assert property ($fell(ramping[0]) |-> g0 == 6'd0 || g0 == 6'd32)
		else $error("ramp ended between end values");
	a_ramp_start_value: assert property ($rose(ramping[0]) |-> g0 == 6'd0 || g0 == 6'd32)
		else $error("ramp started between end values");
endmodule

bind dsg_guard dsg_guard_props u_props (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_irq_trigger(link_irq_trigger),
	.interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b),
	.gain_level(gain_level), .ramping(ramping));

// >>> dsg_guard_tb.sv
// Purpose: self-checking bench for dsg_guard
// Assumes: interpolation 1, samples zero, long detector off, until t_long sets interpolation 2, nonzero samples and the detector on
// Notes: ramp lengths get a few clocks of slack for trigger latency
`timescale 1ns/1ns
`include "dsg_consts.vh"
module testbench;
	reg         clk_sys, rst_n, reg_wr, reg_rd, rotation_arm, link_irq_trigger;
	reg  [11:0] reg_addr;
	reg  [7:0]  reg_wdata;
	reg  [1:0]  short_power_fault, link_fault, sync_rotation, transmit_gate_input;
	reg  [3:0]  main_interp, chan_interp;
	reg  [31:0] sample_i, sample_q;
	wire [7:0]  reg_rdata;
	wire        interrupt_pin_a, interrupt_pin_b;
	wire [11:0] gain_level;
	wire [1:0]  ramping;
	integer     fails, cmp_count, n, r, k;
	dsg_guard dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.short_power_fault(short_power_fault), .link_fault(link_fault),
		.sync_rotation(sync_rotation), .rotation_arm(rotation_arm),
		.transmit_gate_input(transmit_gate_input), .link_irq_trigger(link_irq_trigger),
		.main_interp(main_interp), .chan_interp(chan_interp), .sample_i(sample_i),
		.sample_q(sample_q),
		.interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b),
		.gain_level(gain_level), .ramping(ramping));
	////////////////////////////////////////////////////////////////
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp)
			begin
				fails = fails + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task complete_run;
		begin
			if (fails == 0 && cmp_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	task wr(input [11:0] a, input [7:0] d);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk_sys);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, input [7:0] e);
		begin
			@(posedge clk_sys);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk_sys);
			reg_rd <= 1'b0;
			#1 check("reg_rdata", reg_rdata, e);
		end
	endtask
	// bounded wait: a stuck ramp shows up as a wrong gain afterwards
	task wait_gain(input integer b, input [5:0] t);
		begin
			n = 0;
			while (gain_level[6*b +: 6] !== t && n < 40000)
			begin
				@(posedge clk_sys);
				#1 n = n + 1;
			end
			check("gain", gain_level[6*b +: 6], t);
		end
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		begin
			check("gain_level", gain_level, 12'h820);
			rd(`DSG_A_GAIN_CTRL, `DSG_RST_GAIN_CTRL);
			rd(`DSG_A_FADE_OUT_EN, 8'hc6);
			rd(`DSG_A_FADE_IN_EN, 8'h40);
			rd(`DSG_A_LIMIT_LO, 8'h00);
			rd(`DSG_A_LONG_CTRL, 8'h00);
			rd(`DSG_A_READ_LO, 8'h00);
			rd(12'h7ff, 8'h00);
			wr(`DSG_A_LIMIT_LO, 8'ha5);
			wr(`DSG_A_LIMIT_HI, 8'hff);
			wr(`DSG_A_READ_LO, 8'hff);
			rd(`DSG_A_LIMIT_LO, 8'ha5);
			rd(`DSG_A_LIMIT_HI, 8'h1f);
			rd(`DSG_A_READ_LO, 8'h00);
		end
	endtask
	task t_irq;
		begin
			@(posedge clk_sys);
			link_irq_trigger <= 1'b1;
			repeat (2) @(posedge clk_sys);
			#1 check("irq_ab", {interrupt_pin_a, interrupt_pin_b}, 2'b10);
			wr(`DSG_A_IRQ_ROUTE, 8'h01);
			repeat (2) @(posedge clk_sys);
			#1 check("irq_ab", {interrupt_pin_a, interrupt_pin_b}, 2'b01);
			@(posedge clk_sys);
			link_irq_trigger <= 1'b0;
		end
	endtask
	task t_ramp;
		begin
			wr(`DSG_A_FADE_OUT_EN, 8'hc7);
			repeat (300) @(posedge clk_sys);
			#1 check("gain_gated", gain_level, 12'h820);
			wr(`DSG_A_FADE_OUT_EN, 8'hc6);
			for (r = 0; r < 3; r = r + 1)
			begin
				wr(`DSG_A_GAIN_CTRL, 8'h80 | r);
				wr(`DSG_A_FADE_OUT_EN, 8'hc7);
				wait_gain(0, 6'd0);
				check("down_len", n >= (256 << r) - 2 && n <= (256 << r) + 6, 1);
				repeat (40) @(posedge clk_sys);
				#1 check("held", {ramping, gain_level}, 14'h0800);
				wr(`DSG_A_FADE_IN_EN, 8'hc0);
				wait_gain(0, 6'd32);
				check("up_len", n >= (256 << r) - 2 && n <= (256 << r) + 6, 1);
			end
		end
	endtask
	task t_faults;
		begin
			wr(`DSG_A_BANK_SEL, 8'h01);
			wr(`DSG_A_GAIN_CTRL, 8'h80);
			wr(`DSG_A_FADE_OUT_EN, 8'hce);
			rd(`DSG_A_FADE_OUT_EN, 8'hce);
			for (k = 0; k < 4; k = k + 1)
			begin
				@(posedge clk_sys);
				short_power_fault <= {k == 0, 1'b0};
				link_fault <= {k == 1, 1'b0};
				sync_rotation <= {k == 2, 1'b0};
				transmit_gate_input <= {k != 3, 1'b1};
				wait_gain(1, 6'd0);
				check("bank0", gain_level[5:0], 6'd32);
				@(posedge clk_sys);
				short_power_fault <= 2'b00;
				link_fault <= 2'b00;
				sync_rotation <= 2'b00;
				transmit_gate_input <= 2'b11;
				wr(`DSG_A_FADE_IN_EN, 8'hc0);
				wait_gain(1, 6'd32);
			end
			wr(`DSG_A_FADE_OUT_EN, 8'hc6);
			link_fault <= 2'b10;
			sync_rotation <= 2'b10;
			rotation_arm <= 1'b0;
			repeat (300) @(posedge clk_sys);
			#1 check("link_off", gain_level, 12'h820);
		end
	endtask
	task t_long;
		begin
			wr(`DSG_A_BANK_SEL, 8'h00);
			wr(`DSG_A_LIMIT_LO, 8'h10);
			wr(`DSG_A_LIMIT_HI, 8'h00);
			main_interp <= 4'h2;
			sample_i <= 32'h00001000;
			sample_q <= 32'h0000f000;
			wr(`DSG_A_LONG_CTRL, 8'h80);
			wait_gain(0, 6'd0);
			check("long_len", n >= 5110 && n <= 5120, 1);
			rd(`DSG_A_READ_LO, 8'h20);
			rd(`DSG_A_READ_HI, 8'h00);
			wr(`DSG_A_LONG_CTRL, 8'h00);
			wr(`DSG_A_FADE_IN_EN, 8'h80);
			wait_gain(0, 6'd32);
			repeat (300) @(posedge clk_sys);
			#1 check("long_off", gain_level, 12'h820);
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial
	begin
		#(40 * 60000);
		fails = fails + 1;
		complete_run;
	end
	initial
	begin
		fails = 0;
		cmp_count = 0;
		{rst_n, reg_wr, reg_rd, link_irq_trigger, reg_addr, reg_wdata} = 0;
		{short_power_fault, link_fault, sync_rotation} = 6'h0;
		rotation_arm = 1'b1;
		transmit_gate_input = 2'b11;
		main_interp = 4'h1;
		chan_interp = 4'h1;
		sample_i = 32'h0;
		sample_q = 32'h0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset;
		t_irq;
		t_ramp;
		t_faults;
		t_long;
		complete_run;
	end
endmodule
